// ==== rtl/feil_pkg.sv ====
package feil_pkg;

  localparam int FEIL_NREG = 5;

  // Register offsets on the management bus, banks a..e in order
  localparam logic [7:0] FEIL_STATUS_ADDR [FEIL_NREG] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h33};
  localparam logic [7:0] FEIL_CLEAR_ADDR [FEIL_NREG] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
  localparam logic [7:0] FEIL_MASK_ADDR [FEIL_NREG] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
  localparam logic [7:0] FEIL_PG_MODE_ADDR = 8'h2F;

  // Bank indices
  localparam int FEIL_BANK_A = 0;
  localparam int FEIL_BANK_B = 1;
  localparam int FEIL_BANK_C = 2;
  localparam int FEIL_BANK_D = 3;
  localparam int FEIL_BANK_E = 4;

  // Status bit positions
  localparam int FEIL_A_VIN_OV = 0;
  localparam int FEIL_A_PG_C = 2;
  localparam int FEIL_A_PG_B = 3;
  localparam int FEIL_A_PG_A = 5;
  localparam int FEIL_A_CRIT = 6;
  localparam int FEIL_B_HP_C = 0;
  localparam int FEIL_B_HP_A = 3;
  localparam int FEIL_B_LDO18_PG = 5;
  localparam int FEIL_B_HOT = 7;
  localparam int FEIL_C_PARITY = 2;
  localparam int FEIL_C_PEC = 3;
  localparam int FEIL_C_OV_C = 4;
  localparam int FEIL_C_OV_B = 5;
  localparam int FEIL_C_OV_A = 7;
  localparam int FEIL_D_UV_C = 0;
  localparam int FEIL_D_UV_B = 1;
  localparam int FEIL_D_UV_A = 3;
  localparam int FEIL_D_ILIM_C = 4;
  localparam int FEIL_D_ILIM_B = 5;
  localparam int FEIL_D_ILIM_A = 7;
  localparam int FEIL_E_LDO10_PG = 2;

  // Implemented status bits, clear bits, maskable bits and power-good events per bank
  localparam logic [7:0] FEIL_STATUS_USED [FEIL_NREG] = '{8'h6D, 8'hA9, 8'hBC, 8'hBB, 8'h04};
  localparam logic [7:0] FEIL_CLEAR_VALID [FEIL_NREG] = '{8'h2D, 8'hA9, 8'hBC, 8'hBB, 8'h04};
  localparam logic [7:0] FEIL_PG_EVENTS [FEIL_NREG] = '{8'h2C, 8'h20, 8'h00, 8'h00, 8'h04};

  localparam logic [7:0] FEIL_MASK_RESET = 8'h00;
  localparam logic [7:0] FEIL_ZERO_BYTE = 8'h00;

  // Power-good mode field
  localparam int FEIL_PG_MODE_LSB = 0;
  localparam int FEIL_PG_MODE_W = 2;
  localparam logic [1:0] FEIL_PG_MODE_RESET = 2'h0;
  localparam logic [1:0] FEIL_PG_MODE_MASKED_PULLS = 2'h0;

  // Readback positions of the sensed open-drain pin levels in the mode register
  localparam int FEIL_PIN_IRQ_POS = 7;
  localparam int FEIL_PIN_PG_POS = 6;

endpackage

// ==== rtl/feil_sticky_bank.sv ====
module feil_sticky_bank
  import feil_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] USED = '1
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_bits
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      if (USED[g])
      begin : g_used
        logic bit_q;
        always_ff @(posedge i_clk)
        begin
          if (i_srst)
            bit_q <= 1'b0;
          else if (i_set[g])
            bit_q <= 1'b1;
          else if (i_clr[g])
            bit_q <= 1'b0;
        end
        assign o_bits[g] = bit_q;
      end
      else
      begin : g_unused
        assign o_bits[g] = 1'b0;
      end
    end
  endgenerate

endmodule // feil_sticky_bank

// ==== rtl/feil_shutdown_ctl.sv ====
module feil_shutdown_ctl
  import feil_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_trigger,
  input wire logic i_enable_req,
  output logic o_shutdown,
  output logic o_shutdown_start,
  output logic o_enable_grant
);

  logic shutdown_q;
  logic start_q;
  logic grant_q;

  // Only a reset, standing for a power cycle, releases the shutdown
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      shutdown_q <= 1'b0;
      start_q <= 1'b0;
      grant_q <= 1'b0;
    end
    else
    begin
      shutdown_q <= shutdown_q | i_trigger;
      start_q <= i_trigger & ~shutdown_q;
      grant_q <= i_enable_req & ~shutdown_q & ~i_trigger;
    end
  end

  assign o_shutdown = shutdown_q;
  assign o_shutdown_start = start_q;
  assign o_enable_grant = grant_q;

endmodule // feil_shutdown_ctl

// ==== rtl/feil_top.sv ====
// Contract
// - Unmasked event drives interrupt low and power-good to its defined level.
// - Nine events issue regulator shutdown: input OV/UV, critical temp, buck OV/UV.
// - Other events only update status and outputs; regulators keep running.
// - Input overvoltage: status 0x08[0], clear 0x10[0], mask 0x15[0]; shutdown.
// - Buck a/b/c power-good loss: 0x08 bits 5/3/2; no shutdown; both low.
// - Linear 1v8 and 1v0 power-good loss bits; no shutdown; both outputs low.
// - Buck a/b/c overvoltage: 0x0A bits 7/5/4; shutdown; both outputs low.
// - Buck a/b/c undervoltage: 0x0B bits 3/1/0; shutdown; both outputs low.
// - Input undervoltage has no register bits; always shutdown, both low.
// - Buck current-limit warnings: 0x0B bits 7/5/4; interrupt low only.
// - Buck a high power warning at 0x09[3]; interrupt low only.
// - Buck c high power warning at 0x09[0]; interrupt low only.
// - High temperature warning at 0x09[7]; interrupt low only.
// - Critical temperature at 0x08[6], no clear or mask; shutdown, both low.
// - Bus PEC and parity errors at 0x0A bits 3/2; interrupt low only.
// - Outputs stay asserted until the host clears or masks the event; in mode 00 masking releases the interrupt only.
// - After clear with event gone, interrupt rises; power-good rises unless shut down.
// - Masked with mode 00: interrupt stays high, power-good still pulled low.
// - Status bits latch; write one clears; persisting condition sets again.
// - Interrupt is active-low latched open-drain, released only when causes cleared; masking the causes also releases it.
// - Shutdown starts power-off, forces power-good low, ignores enables until reset.
module feil_top
  import feil_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_bulk_input_supply_ov,
  input wire logic i_bulk_input_supply_uv,
  input wire logic [2:0] i_buck_rail_pg_loss,
  input wire logic [2:0] i_buck_rail_ov,
  input wire logic [2:0] i_buck_rail_uv,
  input wire logic [2:0] i_buck_rail_ilim,
  input wire logic i_buck_rail_a_high_power,
  input wire logic i_buck_rail_c_high_power,
  input wire logic i_linear_reg_1v8_pg_loss,
  input wire logic i_linear_reg_1v0_pg_loss,
  input wire logic i_high_temp_warn,
  input wire logic i_critical_temp,
  input wire logic i_pec_error,
  input wire logic i_parity_error,
  input wire logic i_regulator_enable_pin,
  input wire logic i_regulator_enable_bit,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd_en,
  output logic [7:0] o_reg_rdata,
  input wire logic i_general_status_irq_low_in,
  output logic o_general_status_irq_low_out,
  output logic o_general_status_irq_low_oe,
  input wire logic i_power_ok_out_in,
  output logic o_power_ok_out_out,
  output logic o_power_ok_out_oe,
  output logic o_regulator_shutdown_cmd,
  output logic o_regulator_shutdown_start,
  output logic o_regulator_enable_grant
);

  logic [7:0] set_v [FEIL_NREG];
  logic [7:0] clr_v [FEIL_NREG];
  logic [7:0] status_v [FEIL_NREG];
  logic [7:0] mask_q [FEIL_NREG];
  logic [7:0] irq_src_v [FEIL_NREG];
  logic [7:0] pg_src_v [FEIL_NREG];
  logic [7:0] status_rd_v [FEIL_NREG];
  logic [7:0] mask_rd_v [FEIL_NREG];
  logic [FEIL_NREG-1:0] irq_bank;
  logic [FEIL_NREG-1:0] pg_bank;
  logic [FEIL_PG_MODE_W-1:0] pg_mode_q;
  logic irq_q;
  logic pg_low_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic pin_irq_q;
  logic pin_pg_q;

  wire shutdown_trigger;
  wire shutdown_level;
  wire enable_req;
  wire masked_pg_pulls;
  wire wr_pg_mode;
  wire rd_pg_mode;
  wire [7:0] pg_mode_rd;

  // Event sources mapped onto their status bit positions
  always_comb
  begin
    for (int b = 0; b < FEIL_NREG; b++)
      set_v[b] = FEIL_ZERO_BYTE;
    set_v[FEIL_BANK_A][FEIL_A_VIN_OV] = i_bulk_input_supply_ov;
    set_v[FEIL_BANK_A][FEIL_A_PG_A] = i_buck_rail_pg_loss[0];
    set_v[FEIL_BANK_A][FEIL_A_PG_B] = i_buck_rail_pg_loss[1];
    set_v[FEIL_BANK_A][FEIL_A_PG_C] = i_buck_rail_pg_loss[2];
    set_v[FEIL_BANK_A][FEIL_A_CRIT] = i_critical_temp;
    set_v[FEIL_BANK_B][FEIL_B_LDO18_PG] = i_linear_reg_1v8_pg_loss;
    set_v[FEIL_BANK_B][FEIL_B_HP_A] = i_buck_rail_a_high_power;
    set_v[FEIL_BANK_B][FEIL_B_HP_C] = i_buck_rail_c_high_power;
    set_v[FEIL_BANK_B][FEIL_B_HOT] = i_high_temp_warn;
    set_v[FEIL_BANK_C][FEIL_C_OV_A] = i_buck_rail_ov[0];
    set_v[FEIL_BANK_C][FEIL_C_OV_B] = i_buck_rail_ov[1];
    set_v[FEIL_BANK_C][FEIL_C_OV_C] = i_buck_rail_ov[2];
    set_v[FEIL_BANK_C][FEIL_C_PEC] = i_pec_error;
    set_v[FEIL_BANK_C][FEIL_C_PARITY] = i_parity_error;
    set_v[FEIL_BANK_D][FEIL_D_UV_A] = i_buck_rail_uv[0];
    set_v[FEIL_BANK_D][FEIL_D_UV_B] = i_buck_rail_uv[1];
    set_v[FEIL_BANK_D][FEIL_D_UV_C] = i_buck_rail_uv[2];
    set_v[FEIL_BANK_D][FEIL_D_ILIM_A] = i_buck_rail_ilim[0];
    set_v[FEIL_BANK_D][FEIL_D_ILIM_B] = i_buck_rail_ilim[1];
    set_v[FEIL_BANK_D][FEIL_D_ILIM_C] = i_buck_rail_ilim[2];
    set_v[FEIL_BANK_E][FEIL_E_LDO10_PG] = i_linear_reg_1v0_pg_loss;
  end

  // Masked power-good events still pull power-good low only in mode 00
  assign masked_pg_pulls = (pg_mode_q == FEIL_PG_MODE_MASKED_PULLS);

  genvar g;
  generate
    for (g = 0; g < FEIL_NREG; g++)
    begin : g_bank
      wire wr_clear;
      wire wr_mask;
      wire rd_status;
      wire rd_mask;

      assign wr_clear = i_reg_wr_en && (i_reg_addr == FEIL_CLEAR_ADDR[g]);
      assign wr_mask = i_reg_wr_en && (i_reg_addr == FEIL_MASK_ADDR[g]);
      assign rd_status = (i_reg_addr == FEIL_STATUS_ADDR[g]);
      assign rd_mask = (i_reg_addr == FEIL_MASK_ADDR[g]);

      // Critical temperature has no clear bit, so only reset releases it
      assign clr_v[g] = wr_clear ? (i_reg_wdata & FEIL_CLEAR_VALID[g]) : FEIL_ZERO_BYTE;

      feil_sticky_bank #(
        .W(8),
        .USED(FEIL_STATUS_USED[g])
      ) u_bank (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_set(set_v[g]),
        .i_clr(clr_v[g]),
        .o_bits(status_v[g])
      );

      always_ff @(posedge i_clk)
      begin
        if (i_srst)
          mask_q[g] <= FEIL_MASK_RESET;
        else if (wr_mask)
          mask_q[g] <= i_reg_wdata;
      end

      // Bits without a clear bit (critical temperature) cannot be masked
      assign irq_src_v[g] = status_v[g] & ~(mask_q[g] & FEIL_CLEAR_VALID[g]);
      assign irq_bank[g] = |irq_src_v[g];

      assign pg_src_v[g] = status_v[g] & FEIL_PG_EVENTS[g]
                           & (~mask_q[g] | {8{masked_pg_pulls}});
      assign pg_bank[g] = |pg_src_v[g];

      assign status_rd_v[g] = rd_status ? status_v[g] : FEIL_ZERO_BYTE;
      assign mask_rd_v[g] = rd_mask ? mask_q[g] : FEIL_ZERO_BYTE;
    end
  endgenerate

  // The nine shutdown causes act on the raw condition, whatever the mask
  assign shutdown_trigger = i_bulk_input_supply_ov | i_bulk_input_supply_uv
                            | i_critical_temp | (|i_buck_rail_ov) | (|i_buck_rail_uv);
  assign enable_req = i_regulator_enable_pin | i_regulator_enable_bit;

  feil_shutdown_ctl u_shutdown (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_trigger(shutdown_trigger),
    .i_enable_req(enable_req),
    .o_shutdown(shutdown_level),
    .o_shutdown_start(o_regulator_shutdown_start),
    .o_enable_grant(o_regulator_enable_grant)
  );

  assign wr_pg_mode = i_reg_wr_en && (i_reg_addr == FEIL_PG_MODE_ADDR);
  assign rd_pg_mode = (i_reg_addr == FEIL_PG_MODE_ADDR);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      pg_mode_q <= FEIL_PG_MODE_RESET;
    else if (wr_pg_mode)
      pg_mode_q <= i_reg_wdata[FEIL_PG_MODE_LSB +: FEIL_PG_MODE_W];
  end

  // Sensed pin levels are kept for readback so a wired-OR partner can be seen
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      pin_irq_q <= 1'b1;
      pin_pg_q <= 1'b1;
    end
    else
    begin
      pin_irq_q <= i_general_status_irq_low_in;
      pin_pg_q <= i_power_ok_out_in;
    end
  end

  assign pg_mode_rd = rd_pg_mode ? {pin_irq_q, pin_pg_q, 4'h0, pg_mode_q} : FEIL_ZERO_BYTE;

  // Clear registers and unmapped offsets fall through to zero
  always_comb
  begin
    rdata_d = pg_mode_rd;
    for (int b = 0; b < FEIL_NREG; b++)
      rdata_d = rdata_d | status_rd_v[b] | mask_rd_v[b];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rdata_q <= FEIL_ZERO_BYTE;
    else if (i_reg_rd_en)
      rdata_q <= rdata_d;
  end

  // Input undervoltage has no status bit and is not maskable; it
  // asserts the interrupt for as long as the condition is present.
  // Critical temperature is sticky with no clear, so the pin stays
  // low after it until reset, as the shutdown demands a power cycle.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      irq_q <= 1'b0;
      pg_low_q <= 1'b0;
    end
    else
    begin
      irq_q <= (|irq_bank) | i_bulk_input_supply_uv;
      pg_low_q <= (|pg_bank) | shutdown_level;
    end
  end

  // Warnings reach only irq_q and never the shutdown path
  assign o_general_status_irq_low_out = 1'b0;
  assign o_general_status_irq_low_oe = irq_q;
  assign o_power_ok_out_out = 1'b0;
  assign o_power_ok_out_oe = pg_low_q;
  assign o_regulator_shutdown_cmd = shutdown_level;
  assign o_reg_rdata = rdata_q;

endmodule // feil_top

// ==== dv/feil_top_properties.sv ====
module feil_top_properties
  import feil_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_bulk_input_supply_ov,
  input wire logic i_bulk_input_supply_uv,
  input wire logic [2:0] i_buck_rail_ov,
  input wire logic [2:0] i_buck_rail_uv,
  input wire logic i_critical_temp,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_general_status_irq_low_out,
  input wire logic o_general_status_irq_low_oe,
  input wire logic o_power_ok_out_out,
  input wire logic o_power_ok_out_oe,
  input wire logic o_regulator_shutdown_cmd,
  input wire logic o_regulator_shutdown_start,
  input wire logic o_regulator_enable_grant
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // Raw trigger of the nine shutdown events; masks play no part here
  wire trig = i_bulk_input_supply_ov | i_bulk_input_supply_uv | (|i_buck_rail_ov)
    | (|i_buck_rail_uv) | i_critical_temp;
  a_trigger_shuts_down: assert property (trig |=> o_regulator_shutdown_cmd)
    else $error("shutdown did not follow a trigger event");
  a_no_spurious_shutdown: assert property (!o_regulator_shutdown_cmd && !trig |=> !o_regulator_shutdown_cmd)
    else $error("shutdown without a trigger event");
  a_shutdown_sticks: assert property (o_regulator_shutdown_cmd |=> o_regulator_shutdown_cmd)
    else $error("shutdown released before reset");
  a_start_one_cycle: assert property (o_regulator_shutdown_start |=> !o_regulator_shutdown_start)
    else $error("shutdown start longer than one cycle");
  a_start_on_first: assert property (trig && !o_regulator_shutdown_cmd |=> o_regulator_shutdown_start)
    else $error("first shutdown trigger gave no start pulse");
  a_grant_blocked: assert property (o_regulator_shutdown_cmd |=> !o_regulator_enable_grant)
    else $error("enable granted after shutdown");
  a_pg_forced_low: assert property (o_regulator_shutdown_cmd |=> o_power_ok_out_oe)
    else $error("power good not pulled low after shutdown");
  a_input_uv_irq: assert property (i_bulk_input_supply_uv |=> o_general_status_irq_low_oe)
    else $error("input undervoltage did not assert the interrupt");
  a_irq_open_drain: assert property (o_general_status_irq_low_out == 1'b0)
    else $error("interrupt pin driven high");
  a_pg_open_drain: assert property (o_power_ok_out_out == 1'b0)
    else $error("power good pin driven high");
  a_rdata_holds: assert property (!i_reg_rd_en |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
endmodule // feil_top_properties

bind feil_top feil_top_properties u_feil_top_properties (.i_clk(i_clk), .i_srst(i_srst),
  .i_bulk_input_supply_ov(i_bulk_input_supply_ov), .i_bulk_input_supply_uv(i_bulk_input_supply_uv),
  .i_buck_rail_ov(i_buck_rail_ov), .i_buck_rail_uv(i_buck_rail_uv),
  .i_critical_temp(i_critical_temp), .i_reg_rd_en(i_reg_rd_en), .o_reg_rdata(o_reg_rdata),
  .o_general_status_irq_low_out(o_general_status_irq_low_out),
  .o_general_status_irq_low_oe(o_general_status_irq_low_oe),
  .o_power_ok_out_out(o_power_ok_out_out),
  .o_power_ok_out_oe(o_power_ok_out_oe), .o_regulator_shutdown_cmd(o_regulator_shutdown_cmd),
  .o_regulator_shutdown_start(o_regulator_shutdown_start),
  .o_regulator_enable_grant(o_regulator_enable_grant));

// ==== dv/feil_host_model.sv ====
module feil_host_model (
  input wire logic i_clk,
  input wire logic i_irq_oe,
  input wire logic i_pg_oe,
  input wire logic [7:0] i_rdata,
  output logic o_irq_pin,
  output logic o_pg_pin,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-ups hold both open-drain lines high once released
  assign o_irq_pin = !i_irq_oe;
  assign o_pg_pin = !i_pg_oe;
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  // Idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule // feil_host_model

// ==== dv/fault_event_interrupt_logic_bench.sv ====
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module fault_event_interrupt_logic_bench;
  import feil_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, en_pin, en_bit, wr, rd, irq_out, irq_oe, pg_out, pg_oe;
  logic irq_pin, pg_pin, sd_cmd, sd_start, grant;
  logic [12:0] ev;
  logic [8:0] sd;
  logic [7:0] addr, wdata, rdata, rv;
  int n_fail = 0;
  int total_checks = 0;
  // Non-shutdown events: bank and bit of each status flag
  int bank [13] = '{0, 0, 0, 1, 4, 3, 3, 3, 1, 1, 1, 2, 2};
  int bitp [13] = '{5, 3, 2, 5, 2, 7, 5, 4, 3, 0, 7, 3, 2};
  // Shutdown events; input undervoltage has no flag
  int sbank [9] = '{0, 2, 2, 2, 3, 3, 3, -1, 0};
  int sbit [9] = '{0, 7, 5, 4, 3, 1, 0, 0, 6};
  feil_top u_feil_top (.i_clk(clk), .i_srst(srst), .i_bulk_input_supply_ov(sd[0]),
    .i_bulk_input_supply_uv(sd[7]), .i_buck_rail_pg_loss(ev[2:0]), .i_buck_rail_ov(sd[3:1]),
    .i_buck_rail_uv(sd[6:4]), .i_buck_rail_ilim(ev[7:5]), .i_buck_rail_a_high_power(ev[8]),
    .i_buck_rail_c_high_power(ev[9]), .i_linear_reg_1v8_pg_loss(ev[3]),
    .i_linear_reg_1v0_pg_loss(ev[4]), .i_high_temp_warn(ev[10]), .i_critical_temp(sd[8]),
    .i_pec_error(ev[11]), .i_parity_error(ev[12]), .i_regulator_enable_pin(en_pin),
    .i_regulator_enable_bit(en_bit), .i_reg_addr(addr), .i_reg_wr_en(wr), .i_reg_wdata(wdata),
    .i_reg_rd_en(rd), .o_reg_rdata(rdata), .i_general_status_irq_low_in(irq_pin),
    .o_general_status_irq_low_out(irq_out), .o_general_status_irq_low_oe(irq_oe),
    .i_power_ok_out_in(pg_pin), .o_power_ok_out_out(pg_out), .o_power_ok_out_oe(pg_oe),
    .o_regulator_shutdown_cmd(sd_cmd), .o_regulator_shutdown_start(sd_start),
    .o_regulator_enable_grant(grant));
  feil_host_model u_feil_host_model (.i_clk(clk), .i_irq_oe(irq_oe), .i_pg_oe(pg_oe),
    .i_rdata(rdata), .o_irq_pin(irq_pin), .o_pg_pin(pg_pin), .o_addr(addr), .o_wr(wr),
    .o_wdata(wdata), .o_rd(rd));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    u_feil_host_model.rd(a, rv);
    `CHK("rdata", exp, rv)
  endtask
  task automatic fire(input logic [12:0] e, input logic [8:0] s);
    @(negedge clk);
    ev = e;
    sd = s;
    @(negedge clk);
    ev = '0;
    sd = '0;
    @(negedge clk);
  endtask
  task automatic do_reset;
    @(negedge clk);
    srst = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    ev = '0;
    sd = '0;
    srst = 1'b1;
    en_pin = 1'b0;
    en_bit = 1'b0;
    do_reset();
    for (int i = 0; i < FEIL_NREG; i++)
    begin
      chk_rd(FEIL_MASK_ADDR[i], FEIL_MASK_RESET);
      chk_rd(FEIL_STATUS_ADDR[i], FEIL_ZERO_BYTE);
      chk_rd(FEIL_CLEAR_ADDR[i], FEIL_ZERO_BYTE);
    end
    chk_rd(FEIL_PG_MODE_ADDR, 8'hC0);
    chk_rd(8'h40, 8'h00);
    u_feil_host_model.wr(8'h08, 8'hFF);
    chk_rd(8'h08, 8'h00);
    u_feil_host_model.wr(8'h17, 8'h0C);
    chk_rd(8'h17, 8'h0C);
    fire(13'h0800, 9'h000);
    `CHK("irq_oe", 1'b0, irq_oe)
    chk_rd(8'h0A, 8'h08);
    u_feil_host_model.wr(8'h12, 8'h08);
    u_feil_host_model.wr(8'h17, 8'h00);
    for (int i = 0; i < 13; i++)
    begin
      fire(13'(1 << i), 9'h000);
      `CHK("irq_oe", 1'b1, irq_oe)
      `CHK("pg_oe", FEIL_PG_EVENTS[bank[i]][bitp[i]], pg_oe)
      repeat (4) @(negedge clk);
      `CHK("irq_oe", 1'b1, irq_oe)
      chk_rd(FEIL_STATUS_ADDR[bank[i]], 8'(1 << bitp[i]));
      u_feil_host_model.wr(FEIL_CLEAR_ADDR[bank[i]], 8'(1 << bitp[i]));
      @(negedge clk);
      `CHK("irq_oe", 1'b0, irq_oe)
      `CHK("pg_oe", 1'b0, pg_oe)
      `CHK("sd_cmd", 1'b0, sd_cmd)
    end
    u_feil_host_model.wr(8'h15, 8'h20);
    fire(13'h0001, 9'h000);
    `CHK("irq_oe", 1'b0, irq_oe)
    `CHK("pg_oe", 1'b1, pg_oe)
    u_feil_host_model.wr(8'h10, 8'h20);
    u_feil_host_model.wr(8'h15, 8'h00);
    `CHK("pg_oe", 1'b0, pg_oe)
    @(negedge clk);
    ev[10] = 1'b1;
    repeat (2) @(negedge clk);
    u_feil_host_model.wr(8'h11, 8'h80);
    @(negedge clk);
    `CHK("irq_oe", 1'b1, irq_oe)
    chk_rd(8'h09, 8'h80);
    ev[10] = 1'b0;
    u_feil_host_model.wr(8'h11, 8'h80);
    @(negedge clk);
    `CHK("irq_oe", 1'b0, irq_oe)
    en_pin = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("grant", 1'b1, grant)
    en_pin = 1'b0;
    en_bit = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("grant", 1'b1, grant)
    for (int i = 0; i < 9; i++)
    begin
      fire(13'h0000, 9'(1 << i));
      `CHK("sd_cmd", 1'b1, sd_cmd)
      `CHK("pg_oe", 1'b1, pg_oe)
      `CHK("grant", 1'b0, grant)
      if (i != 7)
        `CHK("irq_oe", 1'b1, irq_oe)
      else
        `CHK("irq_oe", 1'b0, irq_oe)
      if (sbank[i] >= 0)
        chk_rd(FEIL_STATUS_ADDR[sbank[i]], 8'(1 << sbit[i]));
      if (i == 1)
      begin
        u_feil_host_model.wr(8'h12, 8'h80);
        @(negedge clk);
        `CHK("irq_oe", 1'b0, irq_oe)
        `CHK("pg_oe", 1'b1, pg_oe)
      end
      if (i == 8)
      begin
        u_feil_host_model.wr(8'h10, 8'h40);
        chk_rd(8'h08, 8'h40);
      end
      do_reset();
    end
    wrap_up();
  end
endmodule // fault_event_interrupt_logic_bench
